/* hw/card_detect_pkg.sv */
// shared constants, types and register map of the card-detect sequencer
package card_detect_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STANDBY   = 8'h04;
  localparam logic [7:0] OFS_SENSE     = 8'h08;
  localparam logic [7:0] OFS_THRESH    = 8'h0C;
  localparam logic [7:0] OFS_CAL       = 8'h10;
  localparam logic [7:0] OFS_XTAL      = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;
  localparam logic [7:0] OFS_REF_IQ    = 8'h1C;
  localparam logic [7:0] OFS_MEAS_IQ   = 8'h20;
  localparam logic [7:0] OFS_ULP_REF   = 8'h24;

  // control register fields
  localparam int CTRL_START_BIT   = 0;
  localparam int CTRL_MODE_LSB    = 1;
  localparam int CTRL_DPC_BIT     = 3;
  localparam int CTRL_PINAB_BIT   = 4;
  localparam int CTRL_ACK_BIT     = 5;
  localparam int CTRL_STOP_BIT    = 6;

  // mode encodings
  localparam logic [1:0] MODE_LOW_POWER = 2'h0;
  localparam logic [1:0] MODE_SEMI_AUTO = 2'h1;
  localparam logic [1:0] MODE_ULTRA_LOW = 2'h2;

  // reset values
  localparam logic [31:0] RST_STANDBY = 32'h0000_0010;
  localparam logic [15:0] RST_SENSE   = 16'h0008;
  localparam logic [15:0] RST_THRESH  = 16'h0010;
  localparam logic [15:0] RST_TARGET  = 16'h0080;
  localparam logic [7:0]  RST_HYST    = 8'h04;
  localparam logic [7:0]  RST_XTAL    = 8'h01;
  localparam logic [3:0]  RST_AVG_LOG = 4'h2;

  // crystal poll unit is 256 carrier periods (13.56 MHz) at 250 MHz
  localparam real CARRIER_MHZ      = 13.56;
  localparam real CLK_MHZ          = 250.0;
  localparam int  XTAL_UNIT_CYCLES = int'(256.0 * CLK_MHZ / CARRIER_MHZ);

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {
    ST_IDLE, ST_CAL_ADJ, ST_CAL_REF, ST_STANDBY, ST_XTAL, ST_FIELD_ON, ST_SENSE, ST_EVAL
  } seq_e;

  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
  } iq_s;

  typedef struct packed {
    logic        start;
    logic [1:0]  mode;
    logic        dynamic_power_control;
    logic        pin_abort;
    logic        stop;
  } cmd_s;

endpackage

/* hw/iq_averager.sv */
// accumulates I/Q samples and yields their power-of-two average
`timescale 1ns/1ps
`default_nettype none
module iq_averager
  import card_detect_pkg::*;
#(
  parameter int ACC_W = 24
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       clear,
  input  wire logic       sample_valid,
  input  wire iq_s        sample,
  input  wire logic [3:0] avg_log,
  output logic            done,
  output iq_s             average
);

  logic [ACC_W-1:0] acc_i_r;
  logic [ACC_W-1:0] acc_q_r;
  logic [15:0]      cnt_r;
  logic [15:0]      target;

  assign target = 16'(16'h0001 << avg_log);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_i_r <= '0;
      acc_q_r <= '0;
      cnt_r   <= '0;
      done    <= 1'b0;
      average <= '0;
    end else if (clear) begin
      acc_i_r <= '0;
      acc_q_r <= '0;
      cnt_r   <= '0;
      done    <= 1'b0;
    end else if (sample_valid && !done) begin
      if (cnt_r + 16'h0001 == target) begin
        done      <= 1'b1;
        average.i <= 16'((acc_i_r + ACC_W'(sample.i)) >> avg_log);
        average.q <= 16'((acc_q_r + ACC_W'(sample.q)) >> avg_log);
      end
      acc_i_r <= acc_i_r + ACC_W'(sample.i);
      acc_q_r <= acc_q_r + ACC_W'(sample.q);
      cnt_r   <= cnt_r + 16'h0001;
    end
  end

endmodule
`default_nettype wire

/* hw/card_detect_seq.sv */
// energy-saving card detection sequencer with AXI4-Lite registers
// Function
// - low-power loop starts with standby timed by the wake-up counter
// - after standby field on for sense time, then compare I/Q to references
// - I or Q beyond reference by margin raises card-detect interrupt, loop ends
// - frontend protocol settings are not restored; host reprograms after wake-up
// - no excess means no interrupt and straight return to standby
// - loop ends on detect, reset, host select, RF level or pin toggle
// - without power control the field uses type A 106 kbit/s settings
// - with power control the field-on command runs when standby expires
// - with power control sense timer starts after field-on command completes
// - I/Q samples averaged over a configured count before comparing
// - card when measured and reference differ by more than threshold on either channel
// - calibration steers receive gain toward target within hysteresis band
// - wake-up polls crystal readiness every xtal_r intervals of 256 carrier periods
// - semi-autonomous mode returns I/Q, skips standby and threshold check
// - ultra-low-power loop leaves only on detuning, abort pin, stop command or reset
// - during ultra-low-power standby only the wake-up timer runs
// - ultra-low-power calibration stores unloaded strength as reference
// - ultra-low-power measurement reports card when strength differs beyond threshold
// - a setting enables aborting ultra-low-power loop on abort pin change
// - calibration precedes the loop; measurements are relative to it
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module card_detect_seq
  import card_detect_pkg::*;
#(
  parameter int XTAL_UNIT = XTAL_UNIT_CYCLES
) (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        ARST_N,
  // AXI4-Lite write
  input  wire logic [7:0]  S_AWADDR,
  input  wire logic        S_AWVALID,
  output logic             S_AWREADY,
  input  wire logic [31:0] S_WDATA,
  input  wire logic [3:0]  S_WSTRB,
  input  wire logic        S_WVALID,
  output logic             S_WREADY,
  output logic [1:0]       S_BRESP,
  output logic             S_BVALID,
  input  wire logic        S_BREADY,
  // AXI4-Lite read
  input  wire logic [7:0]  S_ARADDR,
  input  wire logic        S_ARVALID,
  output logic             S_ARREADY,
  output logic [31:0]      S_RDATA,
  output logic [1:0]       S_RRESP,
  output logic             S_RVALID,
  input  wire logic        S_RREADY,
  // wake sources
  input  wire logic        HOST_SELECT_LINE,
  input  wire logic        RF_LEVEL_DETECT,
  input  wire logic        ABORT_INPUT_PIN,
  input  wire logic        XTAL_READY,
  // analog frontend
  input  wire logic        SAMPLE_VALID,
  input  wire iq_s         SAMPLE_IQ,
  input  wire logic [15:0] STRENGTH,
  input  wire logic        FIELD_CMD_DONE,
  output logic             FIELD_ENABLE,
  output logic             FIELD_TYPEA_106,
  output logic             FIELD_ENABLE_COMMAND,
  output logic [7:0]       RX_GAIN,
  output logic             XTAL_ENABLE,
  output logic             STANDBY_ACTIVE,
  // host event
  output logic             CARD_DETECT_INTERRUPT
);

  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // registers
  cmd_s        cmd;
  logic [31:0] standby_r;
  logic [15:0] sense_r;
  logic [15:0] thresh_r;
  logic [15:0] target_r;
  logic [7:0]  hyst_r;
  logic [7:0]  xtal_r;
  logic [3:0]  avg_log_r;
  iq_s         ref_r;
  iq_s         meas_r;
  logic [15:0] ulp_ref_r;
  logic [1:0]  mode_r;
  logic        dpc_r;
  logic        pin_abort_r;
  logic        meas_valid_r;
  logic [2:0]  exit_cause_r;
  seq_e        st_r;

  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wr_go;
  logic [31:0] wmask;

  assign wr_go = aw_hold_r && w_hold_r && !S_BVALID;
  assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

  // address and data are latched independently, in either order
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      S_AWREADY <= 1'b0;
      S_WREADY  <= 1'b0;
    end else begin
      S_AWREADY <= !aw_hold_r && !S_AWREADY;
      S_WREADY  <= !w_hold_r && !S_WREADY;
      if (S_AWVALID && S_AWREADY) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= S_AWADDR;
        S_AWREADY <= 1'b0;
      end else if (wr_go) begin
        aw_hold_r <= 1'b0;
      end
      if (S_WVALID && S_WREADY) begin
        w_hold_r <= 1'b1;
        wdata_r  <= S_WDATA;
        wstrb_r  <= S_WSTRB;
        S_WREADY <= 1'b0;
      end else if (wr_go) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= OFS_ULP_REF);
  endfunction

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      S_BVALID <= 1'b0;
      S_BRESP  <= RESP_OKAY;
    end else if (wr_go) begin
      S_BVALID <= 1'b1;
      S_BRESP  <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_BREADY) begin
      S_BVALID <= 1'b0;
    end
  end

  // configuration writes; control bits other than mode/dpc/pin are pulses
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cmd       <= '0;
      standby_r <= RST_STANDBY;
      sense_r   <= RST_SENSE;
      thresh_r  <= RST_THRESH;
      target_r  <= RST_TARGET;
      hyst_r    <= RST_HYST;
      xtal_r    <= RST_XTAL;
      avg_log_r <= RST_AVG_LOG;
    end else begin
      cmd.start <= 1'b0;
      cmd.stop  <= 1'b0;
      if (wr_go) begin
        case (awaddr_r)
          OFS_CTRL: begin
            if (wstrb_r[0]) begin
              cmd.start     <= wdata_r[CTRL_START_BIT];
              cmd.mode      <= wdata_r[CTRL_MODE_LSB +: 2];
              cmd.dynamic_power_control       <= wdata_r[CTRL_DPC_BIT];
              cmd.pin_abort <= wdata_r[CTRL_PINAB_BIT];
              cmd.stop      <= wdata_r[CTRL_STOP_BIT];
            end
          end
          OFS_STANDBY: standby_r <= (standby_r & ~wmask) | (wdata_r & wmask);
          OFS_SENSE: begin
            sense_r   <= (sense_r & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0]);
            if (wstrb_r[2]) avg_log_r <= wdata_r[19:16];
          end
          OFS_THRESH: thresh_r <= (thresh_r & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0]);
          OFS_CAL: begin
            target_r <= (target_r & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0]);
            if (wstrb_r[2]) hyst_r <= wdata_r[23:16];
          end
          OFS_XTAL: if (wstrb_r[0]) xtal_r <= wdata_r[7:0];
          default: ;
        endcase
      end
    end
  end

  logic ack_pulse;
  assign ack_pulse = wr_go && awaddr_r == OFS_CTRL && wstrb_r[0] && wdata_r[CTRL_ACK_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // read channel, one cycle answer
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      S_ARREADY <= 1'b0;
      S_RVALID  <= 1'b0;
      S_RDATA   <= '0;
      S_RRESP   <= RESP_OKAY;
    end else begin
      // ready never waits for valid to drop, which would lock a master holding its request
      S_ARREADY <= !S_RVALID;
      if (S_ARVALID && S_ARREADY) begin
        S_ARREADY <= 1'b0;
        S_RVALID  <= 1'b1;
        S_RRESP   <= mapped(S_ARADDR) ? RESP_OKAY : RESP_SLVERR;
        case (S_ARADDR)
          OFS_CTRL:    S_RDATA <= {25'h0, 1'b0, 1'b0, pin_abort_r, dpc_r, mode_r, 1'b0};
          OFS_STANDBY: S_RDATA <= standby_r;
          OFS_SENSE:   S_RDATA <= {12'h0, avg_log_r, sense_r};
          OFS_THRESH:  S_RDATA <= {16'h0, thresh_r};
          OFS_CAL:     S_RDATA <= {8'h0, hyst_r, target_r};
          OFS_XTAL:    S_RDATA <= {24'h0, xtal_r};
          OFS_STATUS:  S_RDATA <= {16'h0, RX_GAIN, 1'b0, exit_cause_r, meas_valid_r,
                                   CARD_DETECT_INTERRUPT, STANDBY_ACTIVE, st_r != ST_IDLE};
          OFS_REF_IQ:  S_RDATA <= ref_r;
          OFS_MEAS_IQ: S_RDATA <= meas_r;
          OFS_ULP_REF: S_RDATA <= {16'h0, ulp_ref_r};
          default:     S_RDATA <= '0;
        endcase
      end else if (S_RVALID && S_RREADY) begin
        S_RVALID <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  logic [31:0] cnt_r;
  logic [15:0] xunit_r;
  logic        cmd_sent_r;
  logic        pin_prev_r;
  logic        avg_clear;
  logic        avg_done;
  iq_s         avg_iq;
  logic        ulp;
  logic        abort;
  logic        hit;
  logic        toggled;
  logic        pin_chg_r;

  assign ulp       = mode_r == MODE_ULTRA_LOW;
  assign avg_clear = st_r != ST_SENSE;
  assign toggled = pin_chg_r || ABORT_INPUT_PIN != pin_prev_r;
  assign abort = ulp ? (pin_abort_r && toggled)
                     : (HOST_SELECT_LINE || RF_LEVEL_DETECT || toggled);

  // a toggle outside standby is kept until the loop can act on it
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_chg_r <= 1'b0;
    end else begin
      pin_chg_r <= st_r != ST_IDLE && toggled;
    end
  end
  assign hit = ulp ? absdiff(STRENGTH, ulp_ref_r) > thresh_r
                   : (absdiff(avg_iq.i, ref_r.i) > thresh_r) || (absdiff(avg_iq.q, ref_r.q) > thresh_r);

  iq_averager #(.ACC_W(24)) u_avg (
    .clk          (CLK_SYS),
    .arst_n       (ARST_N),
    .clear        (avg_clear),
    .sample_valid (SAMPLE_VALID),
    .sample       (SAMPLE_IQ),
    .avg_log      (avg_log_r),
    .done         (avg_done),
    .average      (avg_iq)
  );

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r         <= ST_IDLE;
      cnt_r        <= '0;
      xunit_r      <= '0;
      mode_r       <= MODE_LOW_POWER;
      dpc_r        <= 1'b0;
      pin_abort_r  <= 1'b0;
      pin_prev_r   <= 1'b0;
      cmd_sent_r   <= 1'b0;
      ref_r        <= '0;
      meas_r       <= '0;
      ulp_ref_r    <= '0;
      meas_valid_r <= 1'b0;
      exit_cause_r <= '0;
      RX_GAIN      <= 8'h80;
      FIELD_ENABLE <= 1'b0;
      FIELD_TYPEA_106       <= 1'b0;
      FIELD_ENABLE_COMMAND  <= 1'b0;
      XTAL_ENABLE           <= 1'b1;
      STANDBY_ACTIVE        <= 1'b0;
      CARD_DETECT_INTERRUPT <= 1'b0;
    end else begin
      pin_prev_r           <= ABORT_INPUT_PIN;
      FIELD_ENABLE_COMMAND <= 1'b0;
      // sticky interrupt; a new detect wins over ack
      if (ack_pulse) CARD_DETECT_INTERRUPT <= 1'b0;
      if (cmd.stop && st_r != ST_IDLE) begin
        st_r           <= ST_IDLE;
        FIELD_ENABLE   <= 1'b0;
        STANDBY_ACTIVE <= 1'b0;
        XTAL_ENABLE    <= 1'b1;
      end else begin
        case (st_r)
          ST_IDLE: begin
            if (cmd.start) begin
              mode_r       <= cmd.mode;
              dpc_r        <= cmd.dynamic_power_control;
              pin_abort_r  <= cmd.pin_abort;
              meas_valid_r <= 1'b0;
              exit_cause_r <= '0;
              // a fresh loop recalibrates; semi mode may reuse its reference
              if (cmd.mode != MODE_SEMI_AUTO) ref_r <= '0;
              cnt_r        <= {16'h0, sense_r};
              FIELD_ENABLE    <= 1'b1;
              FIELD_TYPEA_106 <= !cmd.dynamic_power_control;
              st_r            <= ST_CAL_ADJ;
            end
          end
          ST_CAL_ADJ: begin
            if (cnt_r != 0) begin
              cnt_r <= cnt_r - 32'h1;
            end else if (mode_r == MODE_ULTRA_LOW || mode_r == MODE_SEMI_AUTO && ref_r != '0) begin
              st_r <= ST_CAL_REF;
            end else if (SAMPLE_VALID) begin
              if (STRENGTH > target_r + 16'(hyst_r) && RX_GAIN != 8'h00) begin
                RX_GAIN <= RX_GAIN - 8'h01;
              end else if (STRENGTH + 16'(hyst_r) < target_r && RX_GAIN != 8'hFF) begin
                RX_GAIN <= RX_GAIN + 8'h01;
              end else begin
                st_r <= ST_CAL_REF;
              end
            end
          end
          ST_CAL_REF: begin
            if (ulp) begin
              if (SAMPLE_VALID) begin
                ulp_ref_r    <= STRENGTH;
                FIELD_ENABLE <= 1'b0;
                cnt_r        <= standby_r;
                st_r         <= ST_STANDBY;
              end
            end else if (avg_done) begin
              if (mode_r != MODE_SEMI_AUTO || ref_r == '0) ref_r <= avg_iq;
              FIELD_ENABLE <= 1'b0;
              cnt_r        <= standby_r;
              st_r         <= (mode_r == MODE_SEMI_AUTO) ? ST_XTAL : ST_STANDBY;
            end else begin
              st_r <= ST_SENSE;
            end
          end
          ST_STANDBY: begin
            STANDBY_ACTIVE <= 1'b1;
            XTAL_ENABLE    <= 1'b0;
            if (abort) begin
              exit_cause_r   <= {HOST_SELECT_LINE, RF_LEVEL_DETECT, 1'b1};
              STANDBY_ACTIVE <= 1'b0;
              XTAL_ENABLE    <= 1'b1;
              st_r           <= ST_IDLE;
            end else if (cnt_r == 0) begin
              STANDBY_ACTIVE <= 1'b0;
              XTAL_ENABLE    <= 1'b1;
              xunit_r        <= 16'(XTAL_UNIT);
              cnt_r          <= {24'h0, xtal_r};
              st_r           <= ST_XTAL;
            end else begin
              cnt_r <= cnt_r - 32'h1;
            end
          end
          ST_XTAL: begin
            // poll every xtal_r intervals of 256/fc units
            if (xunit_r != 0) begin
              xunit_r <= xunit_r - 16'h1;
            end else if (cnt_r > 1) begin
              cnt_r   <= cnt_r - 32'h1;
              xunit_r <= 16'(XTAL_UNIT);
            end else if (XTAL_READY) begin
              FIELD_ENABLE    <= 1'b1;
              FIELD_TYPEA_106 <= !dpc_r;
              cmd_sent_r      <= 1'b0;
              cnt_r           <= {16'h0, sense_r};
              st_r            <= ST_FIELD_ON;
            end else begin
              cnt_r   <= {24'h0, xtal_r};
              xunit_r <= 16'(XTAL_UNIT);
            end
          end
          ST_FIELD_ON: begin
            // type A field without power control
            if (!dpc_r) begin
              st_r <= ST_SENSE;
            end else if (!cmd_sent_r) begin
              FIELD_ENABLE_COMMAND <= 1'b1;
              cmd_sent_r           <= 1'b1;
            end else if (FIELD_CMD_DONE) begin
              st_r <= ST_SENSE;
            end
          end
          ST_SENSE: begin
            if (cnt_r != 0) begin
              cnt_r <= cnt_r - 32'h1;
            end else if (ulp || avg_done) begin
              st_r <= (ref_r == '0 && !ulp) ? ST_CAL_REF : ST_EVAL;
            end
          end
          ST_EVAL: begin
            FIELD_ENABLE <= 1'b0;
            meas_r       <= ulp ? {STRENGTH, 16'h0} : avg_iq;
            meas_valid_r <= 1'b1;
            cnt_r        <= standby_r;
            if (mode_r == MODE_SEMI_AUTO) begin
              st_r <= ST_IDLE;
            end else if (hit) begin
              CARD_DETECT_INTERRUPT <= 1'b1;
              exit_cause_r          <= 3'h0;
              st_r                  <= ST_IDLE;
            end else begin
              st_r <= ST_STANDBY;
            end
          end
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* dv/card_detect_monitor.sv */
// port assertions for the card-detect sequencer
`timescale 1ns/1ps
`default_nettype none
module card_detect_monitor
  import card_detect_pkg::*;
(
  // watched ports
  input wire logic       CLK_SYS, ARST_N, S_BVALID, S_BREADY, S_ARVALID, S_ARREADY, S_RVALID, S_RREADY,
  input wire logic [1:0] S_BRESP,
  input wire logic       FIELD_ENABLE, FIELD_ENABLE_COMMAND, STANDBY_ACTIVE, XTAL_ENABLE, CARD_DETECT_INTERRUPT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  a_irq_ack_only: assert property ($fell(CARD_DETECT_INTERRUPT) |-> ##[0:2] S_BVALID)
    else $error("irq dropped");
  a_irq_loop_left: assert property (CARD_DETECT_INTERRUPT |-> !STANDBY_ACTIVE)
    else $error("standby with irq");
  a_standby_quiet: assert property (STANDBY_ACTIVE |-> !FIELD_ENABLE && !XTAL_ENABLE)
    else $error("active in standby");
  a_cmd_pulse: assert property (FIELD_ENABLE_COMMAND |=> !FIELD_ENABLE_COMMAND)
    else $error("long field command");
  a_b_once: assert property (S_BVALID && S_BREADY |=> !S_BVALID) else $error("b repeated");
  a_r_once: assert property (S_RVALID && S_RREADY |=> !S_RVALID) else $error("r repeated");
  a_ar_refused: assert property (S_RVALID |-> !S_ARREADY) else $error("ar while busy");
  a_read_answer: assert property (S_ARVALID && S_ARREADY |=> S_RVALID) else $error("r late");
  a_bresp_code: assert property (S_BVALID |-> S_BRESP == RESP_OKAY || S_BRESP == RESP_SLVERR)
    else $error("bad bresp");
  c_irq: cover property ($rose(CARD_DETECT_INTERRUPT));
  c_standby: cover property ($rose(STANDBY_ACTIVE));
  c_cmd: cover property (FIELD_ENABLE_COMMAND);
endmodule
bind card_detect_seq card_detect_monitor u_card_detect_monitor (.*);
`default_nettype wire

/* dv/frontend_model.sv */
// behavioural analog frontend: samples, strength, command and crystal answers
`timescale 1ns/1ps
`default_nettype none
module frontend_model
  import card_detect_pkg::*;
(
  // from sequencer and bench
  input wire logic    clk, arst_n, field_on, field_cmd, xtal_on, card, slow,
  input wire iq_s     base,
  // towards sequencer
  output logic        smp_valid, cmd_done, xtal_ready,
  output iq_s         smp,
  output logic [15:0] strength
);
  logic [2:0] cmd_r, xt_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {smp_valid, cmd_r, xt_r} <= '0;
      smp <= '0;
      strength <= '0;
    end else begin
      smp_valid <= field_on && !smp_valid;
      // field off: lines toggle so a stale value is never mistaken for a sample
      smp <= field_on ? {base.i + (card ? 16'h0100 : 16'h0000), base.q} : ~smp;
      strength <= field_on ? (card ? 16'h0280 : 16'h0080) : ~strength;
      cmd_r <= field_cmd ? (slow ? 3'h5 : 3'h1) : (cmd_r != 3'h0 ? cmd_r - 3'h1 : 3'h0);
      xt_r <= !xtal_on ? 3'h0 : (xt_r != 3'h3 ? xt_r + 3'h1 : xt_r);
    end
  end
  assign cmd_done = (cmd_r == 3'h1);
  assign xtal_ready = (xt_r == 3'h3);
endmodule
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for the card-detect sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import card_detect_pkg::*;
  logic        clk = 1'b0, arst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic        host_sel = 1'b0, rf_lvl = 1'b0, abort_pin = 1'b0, card = 1'b0, slow = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, sv, cd, xr, f_en, f_a, f_cmd, xt_en, sb, irq, sb_q;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, gain;
  logic [31:0] wdata = 32'h0, rdata, d, seed = 32'hB46D85B3;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] str;
  iq_s         base = '0, smp;
  int          err_count = 0, checks_done = 0, cyc = 0, n_sb = 0, n_cmd = 0, n_a = 0, s0, c0, a0;
  logic [7:0]  ra[7] = '{OFS_STANDBY, OFS_SENSE, OFS_THRESH, OFS_XTAL, OFS_CAL, OFS_STATUS, 8'h30};
  logic [31:0] rv[7] = '{RST_STANDBY, {12'h000, RST_AVG_LOG, RST_SENSE}, {16'h0000, RST_THRESH},
                         {24'h000000, RST_XTAL}, {8'h00, RST_HYST, RST_TARGET}, 32'h00008000, 32'h0};
  initial forever #2 clk = ~clk;
  card_detect_seq #(.XTAL_UNIT(4)) u_card_detect_seq (.CLK_SYS(clk), .ARST_N(arst_n), .S_AWADDR(awaddr),
    .S_AWVALID(awvalid), .S_AWREADY(awready), .S_WDATA(wdata), .S_WSTRB(4'hF), .S_WVALID(wvalid),
    .S_WREADY(wready), .S_BRESP(bresp), .S_BVALID(bvalid), .S_BREADY(1'b1), .S_ARADDR(araddr),
    .S_ARVALID(arvalid), .S_ARREADY(arready), .S_RDATA(rdata), .S_RRESP(rresp), .S_RVALID(rvalid),
    .S_RREADY(1'b1), .HOST_SELECT_LINE(host_sel), .RF_LEVEL_DETECT(rf_lvl), .ABORT_INPUT_PIN(abort_pin),
    .XTAL_READY(xr), .SAMPLE_VALID(sv), .SAMPLE_IQ(smp), .STRENGTH(str), .FIELD_CMD_DONE(cd),
    .FIELD_ENABLE(f_en), .FIELD_TYPEA_106(f_a), .FIELD_ENABLE_COMMAND(f_cmd), .RX_GAIN(gain),
    .XTAL_ENABLE(xt_en), .STANDBY_ACTIVE(sb), .CARD_DETECT_INTERRUPT(irq));
  frontend_model u_frontend_model (.clk(clk), .arst_n(arst_n), .field_on(f_en), .field_cmd(f_cmd),
    .xtal_on(xt_en), .card(card), .slow(slow), .base(base), .smp_valid(sv), .cmd_done(cd),
    .xtal_ready(xr), .smp(smp), .strength(str));
  ////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    sb_q <= sb;
    n_sb += (sb && !sb_q);
    n_cmd += f_cmd;
    n_a += (f_en && f_a);
    if (cyc == 30000) begin
      err_count++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] meas_exp(input iq_s b, input logic c);
    return {b.i + (c ? 16'h0100 : 16'h0000), b.q};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
  task automatic poll(input logic [31:0] m, input logic [31:0] v, input string s);
    int i;
    i = 0;
    do begin
      rd(OFS_STATUS);
      i++;
    end while ((d & m) !== v && i < 400);
    chk(d & m, v, s);
  endtask
  task automatic run(input logic [31:0] c);
    wr(OFS_CTRL, 32'h40);
    wr(OFS_CTRL, c);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 7; k++) begin
      rd(ra[k]);
      chk(d, rv[k], "reset value");
      chk(r, k == 6 ? RESP_SLVERR : RESP_OKAY, "read resp");
    end
    wr(8'h30, 32'hFFFFFFFF);
    chk(r, RESP_SLVERR, "unmapped write");
    seed = lfsr(seed);
    base <= seed;
    wr(OFS_STANDBY, {27'h0, seed[4:0]} + 32'h10);
    wr(OFS_XTAL, 32'h1);
    $display("test registers done");
    s0 = n_sb;
    a0 = n_a;
    run(32'h1);
    repeat (500) @(posedge clk);
    chk(n_sb - s0 >= 2, 1, "loop repeats");
    chk(irq, 0, "no card no irq");
    chk(n_a > a0, 1, "type A field");
    card <= 1'b1;
    poll(32'h4, 32'h4, "card detected");
    s0 = n_sb;
    repeat (60) @(posedge clk);
    chk({irq, n_sb == s0}, 2'h3, "irq held, loop left");
    wr(OFS_CTRL, 32'h20);
    chk(irq, 0, "irq acked");
    card <= 1'b0;
    $display("test low power done");
    for (int k = 0; k < 2; k++) begin
      slow <= k[0];
      c0 = n_cmd;
      a0 = n_a;
      run(32'h9);
      repeat (300) @(posedge clk);
      chk(n_cmd > c0, 1, "field command");
      chk(n_a == a0, 1, "no type A");
      if (k == 0) host_sel <= 1'b1;
      else rf_lvl <= 1'b1;
      poll(32'h1, 32'h0, "wake source ends loop");
      host_sel <= 1'b0;
      rf_lvl <= 1'b0;
    end
    $display("test power control done");
    s0 = n_sb;
    card <= 1'b1;
    run(32'h3);
    poll(32'h8, 32'h8, "semi measured");
    rd(OFS_MEAS_IQ);
    chk(d, meas_exp(base, 1'b1), "semi I/Q");
    chk({irq, n_sb == s0}, 2'h1, "semi no standby, no irq");
    rd(OFS_REF_IQ);
    chk(d, meas_exp(base, 1'b0), "reference I/Q");
    card <= 1'b0;
    $display("test semi done");
    run(32'h15);
    repeat (200) @(posedge clk);
    abort_pin <= 1'b1;
    poll(32'h1, 32'h0, "pin abort");
    run(32'h5);
    abort_pin <= 1'b0;
    repeat (200) @(posedge clk);
    poll(32'h5, 32'h1, "pin ignored");
    card <= 1'b1;
    poll(32'h4, 32'h4, "ultra detect");
    rd(OFS_ULP_REF);
    chk(d, 32'h80, "ultra reference");
    wr(OFS_CTRL, 32'h20);
    $display("test ultra done");
    conclude();
  end
endmodule
`default_nettype wire
